// >>> logic/pmpk_monitor.sv
// Peak-hold power monitor: run control, configuration, sampling sequencer and peak registers.
// Assumes a register agent decodes the serial bus into command-level requests on clk,
// and an analog front end answers each conversion request with one result pulse.
// Operation
// RQ1: Revision block read gives byte count one, then one fixed revision character.
// RQ2: Peak output-current bits 11:0 hold the largest current since last clear.
// RQ3: Writing zero to a peak register clears it; only zero clears.
// RQ4: Peak input-voltage bits 11:0 hold the largest input voltage since last clear.
// RQ5: Peak aux-voltage bits 11:0 hold the largest aux voltage since last clear.
// RQ6: Peak register bits 15:12 always read zero regardless of writes.
// RQ7: Control bits 7:1 read zero; configuration bit 5 reads zero.
// RQ8: Run bit resets to one; sampling runs while one, stops while zero.
// RQ9: In single-shot mode the run bit clears itself after one full cycle.
// RQ10: Continuous mode samples indefinitely until the host writes run bit zero.
// RQ11: Configuration bit 7 selects continuous (one) or single-shot; resets continuous.
// RQ12: Configuration bit 6 adds aux voltage to sampled set; resets zero.
// RQ13: Configuration bits 4:3 select 25 mV or 50 mV range; variant reset.
// RQ14: Configuration bits 2:0 set averaging of two to the code samples; default 111.
// RQ15: Each averaged result replaces its stored peak only when larger.
// RQ16: With aux disabled the aux peak keeps its value unchanged.
`timescale 1ns/1ps
`default_nettype none
`include "pmpk_defs.svh"

module pmpk_monitor #(
   parameter logic [1:0] RANGE_DEFAULT = `PMPK_RANGE_25MV,
   // Revision character value is arbitrary.
   parameter logic [7:0] REV_CHAR      = 8'h52
) (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire pmpk_pkg::pmpk_req_type req,
   output var  pmpk_pkg::pmpk_rsp_type rsp,
   output logic                     conv_req,
   output pmpk_pkg::pmpk_chan_type  conv_chan,
   input  wire logic                conv_done,
   input  wire logic [11:0]         conv_data,
   output logic [1:0]               sense_range,
   output logic [15:0]              alert_line_enables,
   output logic                     sampling_busy,
   output logic                     cycle_done
);
   import pmpk_pkg::*;

   localparam int PW = `PMPK_PEAK_W;

   initial begin
      if (RANGE_DEFAULT != `PMPK_RANGE_25MV && RANGE_DEFAULT != `PMPK_RANGE_50MV) begin
         $error("pmpk_monitor: default sense range must be a defined code");
      end
   end

   // Register state.
   logic            run_r;
   pmpk_config_type cfg_r;
   logic [15:0]     alert_r;
   logic [PW-1:0]   peak_r [3];

   // Sequencer state.
   pmpk_seq_type    seq_r;
   pmpk_chan_type   chan_r;
   logic [2:0]      cyc_avg_r;
   logic            cyc_aux_r;
   logic [7:0]      rounds_r;
   logic            cycle_end;
   logic            sample_take;
   logic            last_chan;
   logic [7:0]      rounds_max;

   // Averager results.
   logic [2:0]      avg_done;
   logic [PW-1:0]   avg_val [3];
   logic            avg_clear;

   function automatic logic cmd_is(input logic [7:0] c, input logic [7:0] k);
      cmd_is = (c == k);
   endfunction

   function automatic logic is_peak_cmd(input logic [7:0] c);
      is_peak_cmd = cmd_is(c, `PMPK_CMD_PEAK_CURRENT) || cmd_is(c, `PMPK_CMD_PEAK_INPUT_VOLTAGE)
                    || cmd_is(c, `PMPK_CMD_PEAK_AUX);
   endfunction

   logic wr_run;
   logic wr_cfg;
   logic wr_alert;

   assign wr_run   = req.wr && cmd_is(req.cmd, `PMPK_CMD_RUN_CONTROL);
   assign wr_cfg   = req.wr && cmd_is(req.cmd, `PMPK_CMD_CONFIG);
   assign wr_alert = req.wr && cmd_is(req.cmd, `PMPK_CMD_ALERT_EN);

   // Run bit: a host write is the newer intent, so it overrides the self-clear.
   always_ff @(posedge clk) begin
      if (rst) begin
         run_r <= 1'(`PMPK_RUN_CONTROL_RESET);                                   // RQ8
      end else if (wr_run) begin
         run_r <= req.wdata[`PMPK_RUN_BIT];                                      // RQ10
      end else if (cycle_end && !cfg_r.continuous) begin
         run_r <= 1'b0;                                                          // RQ9
      end
   end

   logic [7:0] cfg_reset;
   assign cfg_reset = `PMPK_CONFIG_RESET;

   always_ff @(posedge clk) begin
      if (rst) begin
         cfg_r.continuous  <= cfg_reset[`PMPK_MODE_BIT];                         // RQ11
         cfg_r.aux_on      <= cfg_reset[`PMPK_AUX_BIT];                          // RQ12
         cfg_r.sense_range <= RANGE_DEFAULT;                                     // RQ13
         cfg_r.avg_code    <= cfg_reset[`PMPK_AVG_HI:`PMPK_AVG_LO];              // RQ14
      end else if (wr_cfg) begin
         cfg_r.continuous <= req.wdata[`PMPK_MODE_BIT];                          // RQ11
         cfg_r.aux_on     <= req.wdata[`PMPK_AUX_BIT];                           // RQ12
         cfg_r.avg_code   <= req.wdata[`PMPK_AVG_HI:`PMPK_AVG_LO];               // RQ14
         // Reserved range codes are dropped so the front end never sees an undefined range.
         if (req.wdata[`PMPK_RANGE_HI:`PMPK_RANGE_LO] == `PMPK_RANGE_25MV ||
             req.wdata[`PMPK_RANGE_HI:`PMPK_RANGE_LO] == `PMPK_RANGE_50MV) begin
            cfg_r.sense_range <= req.wdata[`PMPK_RANGE_HI:`PMPK_RANGE_LO];      // RQ13
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         alert_r <= `PMPK_ALERT_EN_RESET;
      end else if (wr_alert) begin
         alert_r <= req.wdata;
      end
   end

   assign sense_range        = cfg_r.sense_range;
   assign alert_line_enables = alert_r;

   // Sequencer: one cycle is 2^code rounds over current, input voltage and, if on, aux.
   // Averaging and aux are latched at cycle start (mode is not) so a mid-cycle write cannot
   // leave an averager with a partial sum under a different depth.
   assign rounds_max  = 8'((9'(1) << cyc_avg_r) - 9'(1));
   assign sample_take = (seq_r == PMPK_SEQ_WAIT) && conv_done;
   assign last_chan   = cyc_aux_r ? (chan_r == PMPK_CHAN_AUX) : (chan_r == PMPK_CHAN_VIN);
   assign cycle_end   = sample_take && last_chan && (rounds_r == rounds_max);
   assign avg_clear   = !run_r || (seq_r == PMPK_SEQ_IDLE);

   always_ff @(posedge clk) begin
      if (rst) begin
         seq_r     <= PMPK_SEQ_IDLE;
         chan_r    <= PMPK_CHAN_CURRENT;
         cyc_avg_r <= '0;
         cyc_aux_r <= 1'b0;
         rounds_r  <= '0;
      end else if (!run_r) begin
         seq_r    <= PMPK_SEQ_IDLE;                                              // RQ8
         chan_r   <= PMPK_CHAN_CURRENT;
         rounds_r <= '0;
      end else begin
         unique case (seq_r)
            PMPK_SEQ_IDLE: begin
               cyc_avg_r <= cfg_r.avg_code;                                      // RQ14
               cyc_aux_r <= cfg_r.aux_on;                                        // RQ12
               chan_r    <= PMPK_CHAN_CURRENT;
               rounds_r  <= '0;
               seq_r     <= PMPK_SEQ_REQ;
            end
            PMPK_SEQ_REQ: begin
               seq_r <= PMPK_SEQ_WAIT;
            end
            PMPK_SEQ_WAIT: begin
               if (conv_done) begin
                  if (!last_chan) begin
                     chan_r <= (chan_r == PMPK_CHAN_CURRENT) ? PMPK_CHAN_VIN : PMPK_CHAN_AUX;
                     seq_r  <= PMPK_SEQ_REQ;
                  end else if (rounds_r != rounds_max) begin
                     chan_r   <= PMPK_CHAN_CURRENT;
                     rounds_r <= rounds_r + 8'h01;
                     seq_r    <= PMPK_SEQ_REQ;
                  end else begin
                     // A continuous run re-latches the configuration for the next cycle.
                     seq_r <= PMPK_SEQ_IDLE;                                     // RQ10
                  end
               end
            end
         endcase
      end
   end

   assign conv_req      = run_r && (seq_r == PMPK_SEQ_REQ);
   assign conv_chan     = chan_r;
   assign sampling_busy = run_r && (seq_r != PMPK_SEQ_IDLE);

   always_ff @(posedge clk) begin
      if (rst) begin
         cycle_done <= 1'b0;
      end else begin
         cycle_done <= cycle_end;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_chan
         logic          peak_wr_zero;
         logic [7:0]    peak_cmd;
         logic          update;

         assign peak_cmd     = `PMPK_CMD_PEAK_CURRENT + 8'(gi);
         assign peak_wr_zero = req.wr && cmd_is(req.cmd, peak_cmd)
                               && (req.wdata == `PMPK_PEAK_CLEAR_VALUE);          // RQ3
         // The aux averager only sees samples while aux is in the cycle.
         assign update       = avg_done[gi] && (gi != 2 || cyc_aux_r);            // RQ16

         pmpk_average #(
            .W       (PW),
            .LOG_MAX (`PMPK_AVG_LOG_MAX)
         ) u_avg (
            .clk      (clk),
            .rst      (rst),
            .clear    (avg_clear),
            .avg_code (cyc_avg_r),
            .in_valid (sample_take && (chan_r == pmpk_chan_type'(gi))),
            .in_data  (conv_data),
            .done     (avg_done[gi]),
            .avg      (avg_val[gi])
         );

         // Any result in the clearing cycle wins over the clear, so no peak is lost.
         always_ff @(posedge clk) begin
            if (rst) begin
               peak_r[gi] <= `PMPK_PEAK_RESET;
            end else if (update && (peak_wr_zero || avg_val[gi] > peak_r[gi])) begin
               peak_r[gi] <= avg_val[gi];                                        // RQ15
            end else if (peak_wr_zero) begin
               peak_r[gi] <= `PMPK_PEAK_RESET;                                   // RQ3
            end
         end
      end
   endgenerate

   // Read and write answers, one cycle after the request.
   logic [15:0] rd_mux;
   logic        cmd_known;

   always_comb begin
      rd_mux    = 16'h0000;
      cmd_known = 1'b1;
      unique case (req.cmd)
         `PMPK_CMD_REVISION: begin
            if (req.byte_idx == `PMPK_REV_IDX_COUNT) begin
               rd_mux = {8'h00, `PMPK_REV_BYTE_COUNT};                           // RQ1
            end else if (req.byte_idx == `PMPK_REV_IDX_CHAR) begin
               rd_mux = {8'h00, REV_CHAR};                                       // RQ1
            end
         end
         `PMPK_CMD_PEAK_CURRENT: rd_mux = {4'h0, peak_r[0]};                      // RQ2 RQ6
         `PMPK_CMD_PEAK_INPUT_VOLTAGE:     rd_mux = {4'h0, peak_r[1]};                      // RQ4 RQ6
         `PMPK_CMD_PEAK_AUX:     rd_mux = {4'h0, peak_r[2]};                      // RQ5 RQ6
         `PMPK_CMD_RUN_CONTROL:  rd_mux = {15'h0000, run_r};                      // RQ7
         `PMPK_CMD_CONFIG: begin
            rd_mux = {8'h00, cfg_r.continuous, cfg_r.aux_on, 1'b0,
                      cfg_r.sense_range, cfg_r.avg_code};                         // RQ7
         end
         `PMPK_CMD_ALERT_EN:     rd_mux = alert_r;
         default:                cmd_known = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rsp <= '0;
      end else begin
         rsp.valid <= req.rd || req.wr;
         rsp.err   <= (req.rd || req.wr) && (!cmd_known ||
                      (req.wr && cmd_is(req.cmd, `PMPK_CMD_REVISION)));
         if (req.rd) begin
            rsp.rdata <= rd_mux;
         end
      end
   end

endmodule
`default_nettype wire

// >>> logic/pmpk_defs.svh
// Register offsets, field positions, reset values and fixed figures of the peak monitor.
// Assumes it is included by its bare name from the package and the design modules.
`ifndef PMPK_DEFS_SVH
`define PMPK_DEFS_SVH

`define PMPK_CMD_REVISION      8'h9B
`define PMPK_CMD_PEAK_CURRENT  8'hD0
`define PMPK_CMD_PEAK_INPUT_VOLTAGE      8'hD1
`define PMPK_CMD_PEAK_AUX      8'hD2
`define PMPK_CMD_RUN_CONTROL   8'hD3
`define PMPK_CMD_CONFIG        8'hD4
`define PMPK_CMD_ALERT_EN      8'hD5

`define PMPK_RUN_CONTROL_RESET 8'h01
`define PMPK_CONFIG_RESET      8'h8F
`define PMPK_ALERT_EN_RESET    16'h8000
`define PMPK_PEAK_RESET        12'h000
`define PMPK_PEAK_CLEAR_VALUE  16'h0000

`define PMPK_RUN_BIT           0
`define PMPK_MODE_BIT          7
`define PMPK_AUX_BIT           6
`define PMPK_RSVD_BIT          5
`define PMPK_RANGE_HI          4
`define PMPK_RANGE_LO          3
`define PMPK_AVG_HI            2
`define PMPK_AVG_LO            0

`define PMPK_RANGE_25MV        2'h1
`define PMPK_RANGE_50MV        2'h2
`define PMPK_PEAK_W            12
`define PMPK_AVG_LOG_MAX       7

`define PMPK_REV_BYTE_COUNT    8'h01
`define PMPK_REV_IDX_COUNT     4'h0
`define PMPK_REV_IDX_CHAR      4'h1

`endif

// >>> logic/pmpk_pkg.sv
// Types shared by the peak monitor modules.
// Assumes the constants header is on the include path.
`include "pmpk_defs.svh"

package pmpk_pkg;

   typedef enum logic [1:0] {
      PMPK_CHAN_CURRENT = 2'b00,
      PMPK_CHAN_VIN     = 2'b01,
      PMPK_CHAN_AUX     = 2'b10
   } pmpk_chan_type;

   typedef enum logic [1:0] {
      PMPK_SEQ_IDLE = 2'b00,
      PMPK_SEQ_REQ  = 2'b01,
      PMPK_SEQ_WAIT = 2'b10
   } pmpk_seq_type;

   typedef struct packed {
      logic       continuous;
      logic       aux_on;
      logic [1:0] sense_range;
      logic [2:0] avg_code;
   } pmpk_config_type;

   typedef struct packed {
      logic [7:0]  cmd;
      logic        wr;
      logic        rd;
      logic [15:0] wdata;
      logic [3:0]  byte_idx;
   } pmpk_req_type;

   typedef struct packed {
      logic        valid;
      logic        err;
      logic [15:0] rdata;
   } pmpk_rsp_type;

endpackage

// >>> logic/pmpk_average.sv
// Accumulating averager for one measurement channel.
// Assumes samples arrive as one-cycle pulses on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "pmpk_defs.svh"

module pmpk_average #(
   parameter int W       = `PMPK_PEAK_W,
   parameter int LOG_MAX = `PMPK_AVG_LOG_MAX
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         clear,
   input  wire logic [2:0]   avg_code,
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              done,
   output logic [W-1:0]      avg
);
   import pmpk_pkg::*;

   localparam int ACC_W = W + LOG_MAX;

   logic [ACC_W-1:0]   acc_r;
   logic [LOG_MAX:0]   cnt_r;
   logic [ACC_W-1:0]   acc_nxt;
   logic [LOG_MAX:0]   cnt_nxt;
   logic [LOG_MAX:0]   target;
   logic [ACC_W-1:0]   shifted;

   initial begin
      if (W < 1 || LOG_MAX < 3 || LOG_MAX > 7) begin
         $error("pmpk_average: unsupported width or averaging depth");
      end
   end

   // Code zero means one sample, so the average is the sample itself.
   assign target  = (LOG_MAX+1)'(1) << avg_code;
   assign acc_nxt = acc_r + ACC_W'(in_data);
   assign cnt_nxt = cnt_r + (LOG_MAX+1)'(1);
   assign shifted = acc_nxt >> avg_code;

   always_ff @(posedge clk) begin
      if (rst || clear) begin
         acc_r <= '0;
         cnt_r <= '0;
      end else if (in_valid) begin
         if (cnt_nxt == target) begin
            acc_r <= '0;
            cnt_r <= '0;
         end else begin
            acc_r <= acc_nxt;
            cnt_r <= cnt_nxt;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst || clear) begin
         done <= 1'b0;
         avg  <= '0;
      end else begin
         done <= in_valid && (cnt_nxt == target);
         if (in_valid && (cnt_nxt == target)) begin
            avg <= shifted[W-1:0];
         end
      end
   end

endmodule
`default_nettype wire

// >>> bench/pmpk_monitor_chk.sv
// Concurrent checks on the peak monitor's register bus and sampling ports.
// Assumes it is bound to pmpk_monitor and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module pmpk_monitor_chk #(
   parameter logic [1:0] RANGE_DEFAULT = 2'h1
) (
   input wire logic                   clk,
   input wire logic                   rst,
   input wire pmpk_pkg::pmpk_req_type req,
   input wire pmpk_pkg::pmpk_rsp_type rsp,
   input wire logic                   conv_req,
   input wire logic                   conv_done,
   input wire logic [1:0]             sense_range,
   input wire logic [15:0]            alert_line_enables,
   input wire logic                   sampling_busy,
   input wire logic                   cycle_done
);
   import pmpk_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   rev_count_a: assert property (req.rd && req.cmd == 8'h9B && req.byte_idx == 4'h0
      |=> rsp.rdata == 16'h0001) else $error("revision count wrong");
   peak_rsvd_a: assert property (req.rd && req.cmd inside {8'hD0, 8'hD1, 8'hD2}
      |=> rsp.rdata[15:12] == 4'h0) else $error("peak upper bits set");
   ctrl_rsvd_a: assert property (req.rd && req.cmd == 8'hD3
      |=> rsp.rdata[15:1] == 15'h0000) else $error("control upper bits set");
   cfg_rsvd_a: assert property (req.rd && req.cmd == 8'hD4
      |=> rsp.rdata[15:8] == 8'h00 && !rsp.rdata[5]) else $error("config bit 5 set");
   run_stop_a: assert property (req.wr && req.cmd == 8'hD3 && !req.wdata[0]
      |=> !sampling_busy && !conv_req) else $error("sampling after stop");
   range_take_a: assert property (req.wr && req.cmd == 8'hD4 && ^req.wdata[4:3]
      |=> sense_range == $past(req.wdata[4:3])) else $error("range not taken");
   range_keep_a: assert property (req.wr && req.cmd == 8'hD4 && !(^req.wdata[4:3])
      |=> $stable(sense_range)) else $error("reserved range taken");
   reset_vals_a: assert property ($fell(rst)
      |-> sense_range == RANGE_DEFAULT && alert_line_enables == 16'h8000)
      else $error("reset values wrong");
   done_cause_a: assert property (cycle_done |-> $past(conv_done))
      else $error("cycle done without result");
endmodule
bind pmpk_monitor pmpk_monitor_chk #(.RANGE_DEFAULT(RANGE_DEFAULT)) u_chk (
   .clk(clk), .rst(rst), .req(req), .rsp(rsp), .conv_req(conv_req),
   .conv_done(conv_done), .sense_range(sense_range),
   .alert_line_enables(alert_line_enables), .sampling_busy(sampling_busy),
   .cycle_done(cycle_done));
`default_nettype wire

// >>> bench/pmpk_front_end_model.sv
// Behavioural analog front end answering each conversion request after a set delay.
// Assumes requests are one-cycle pulses; a new request restarts a pending one.
`timescale 1ns/1ps
`default_nettype none
module pmpk_front_end_model (
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire logic                    conv_req,
   input  wire pmpk_pkg::pmpk_chan_type conv_chan,
   input  wire logic [3:0]              delay,
   input  wire logic [11:0]             val_cur,
   input  wire logic [11:0]             val_vin,
   input  wire logic [11:0]             val_aux,
   output logic                         conv_done,
   output logic [11:0]                  conv_data
);
   import pmpk_pkg::*;
   logic          busy_r;
   logic [3:0]    wait_r;
   pmpk_chan_type chan_r;
   logic [11:0]   data_r;
   // Outside the result cycle the lines show the inverse, so late sampling cannot pass.
   assign conv_data = conv_done ? data_r : ~data_r;
   always_ff @(posedge clk) begin
      if (rst) begin
         busy_r    <= 1'b0;
         conv_done <= 1'b0;
         data_r    <= 12'h000;
      end else begin
         conv_done <= busy_r && wait_r == 4'h0 && !conv_req;
         if (conv_req) begin
            busy_r <= 1'b1;
            wait_r <= delay;
            chan_r <= conv_chan;
         end else if (busy_r && wait_r == 4'h0) begin
            busy_r <= 1'b0;
            data_r <= chan_r == PMPK_CHAN_CURRENT ? val_cur :
                      chan_r == PMPK_CHAN_VIN ? val_vin : val_aux;
         end else if (busy_r) begin
            wait_r <= wait_r - 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// >>> bench/pmpk_monitor_tb_top.sv
// Self-checking bench for the peak monitor: register accesses and sampling runs.
// Assumes the design package and header are compiled first and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module pmpk_monitor_tb_top;
   import pmpk_pkg::*;
   // Revision character value is arbitrary.
   localparam logic [7:0] REV_CHAR = 8'h5A;
   logic          clk;
   logic          rst;
   pmpk_req_type  req;
   pmpk_rsp_type  rsp;
   logic          conv_req;
   pmpk_chan_type conv_chan;
   logic          conv_done;
   logic [11:0]   conv_data;
   logic [1:0]    sense_range;
   logic [15:0]   alert_line_enables;
   logic          sampling_busy;
   logic          cycle_done;
   logic [3:0]    fe_delay;
   logic [11:0]   v_cur;
   logic [11:0]   v_vin;
   logic [11:0]   v_aux;
   int            bad_count;
   int            checked;
   int            cycles;
   int            nconv;
   pmpk_monitor #(.RANGE_DEFAULT(2'h1), .REV_CHAR(REV_CHAR)) dut (
      .clk(clk), .rst(rst), .req(req), .rsp(rsp), .conv_req(conv_req),
      .conv_chan(conv_chan), .conv_done(conv_done), .conv_data(conv_data),
      .sense_range(sense_range), .alert_line_enables(alert_line_enables),
      .sampling_busy(sampling_busy), .cycle_done(cycle_done));
   pmpk_front_end_model u_fe (
      .clk(clk), .rst(rst), .conv_req(conv_req), .conv_chan(conv_chan), .delay(fe_delay),
      .val_cur(v_cur), .val_vin(v_vin), .val_aux(v_aux), .conv_done(conv_done),
      .conv_data(conv_data));
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (conv_req === 1'b1) nconv++;
      if (cycles == 20000) begin
         bad_count++;
         end_sim();
      end
   end
   task automatic end_sim;
      if (bad_count == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                       input logic [3:0] i, input logic er);
      @(negedge clk);
      req = '{c, w, !w, d, i};
      @(negedge clk);
      req = '0;
      chk($sformatf("valid %h", c), 16'h0001, {15'h0000, rsp.valid});
      chk($sformatf("err %h", c), {15'h0000, er}, {15'h0000, rsp.err});
   endtask
   task automatic rd(input logic [7:0] c, input logic [15:0] e);
      xfer(1'b0, c, 16'h0000, 4'h0, 1'b0);
      chk($sformatf("reg %h", c), e, rsp.rdata);
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      xfer(1'b1, c, d, 4'h0, 1'b0);
   endtask
   task automatic wait_done;
      int k;
      k = 0;
      @(negedge clk);
      while (cycle_done !== 1'b1 && k < 3000) begin
         @(negedge clk);
         k++;
      end
      chk("cycle_done", 16'h0001, {15'h0000, cycle_done});
   endtask
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      req = '0;
      // A slow front end first, then a prompt one, so both answer timings are seen.
      fe_delay = 4'h3;
      v_cur = 12'h100;
      v_vin = 12'h200;
      v_aux = 12'h300;
      bad_count = 0;
      checked = 0;
      cycles = 0;
      nconv = 0;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      rd(8'hD0, 16'h0000);
      rd(8'hD1, 16'h0000);
      rd(8'hD2, 16'h0000);
      rd(8'hD3, 16'h0001);
      rd(8'hD4, 16'h008F);
      rd(8'hD5, 16'h8000);
      xfer(1'b0, 8'h9B, 16'h0000, 4'h0, 1'b0);
      chk("rev count", 16'h0001, rsp.rdata);
      xfer(1'b0, 8'h9B, 16'h0000, 4'h1, 1'b0);
      chk("rev char", {8'h00, REV_CHAR}, rsp.rdata);
      xfer(1'b1, 8'h9B, 16'h0000, 4'h0, 1'b1);
      xfer(1'b0, 8'hD6, 16'h0000, 4'h0, 1'b1);
      wr(8'hD3, 16'h0000);
      chk("busy", 16'h0000, {15'h0000, sampling_busy});
      wr(8'hD4, 16'h00A9);
      rd(8'hD4, 16'h0089);
      wr(8'hD4, 16'h0091);
      chk("range", 16'h0002, {14'h0000, sense_range});
      wr(8'hD4, 16'h0099);
      wr(8'hD4, 16'h0083);
      rd(8'hD4, 16'h0093);
      wr(8'hD5, 16'h1234);
      rd(8'hD5, 16'h1234);
      wr(8'hD4, 16'h004A);
      nconv = 0;
      wr(8'hD3, 16'h0001);
      wait_done;
      repeat (2) @(negedge clk);
      chk("conversions", 16'h000C, nconv[15:0]);
      chk("busy", 16'h0000, {15'h0000, sampling_busy});
      rd(8'hD3, 16'h0000);
      rd(8'hD0, 16'h0100);
      rd(8'hD1, 16'h0200);
      rd(8'hD2, 16'h0300);
      wr(8'hD0, 16'hF050);
      rd(8'hD0, 16'h0100);
      wr(8'hD1, 16'h0000);
      rd(8'hD1, 16'h0000);
      v_cur = 12'h070;
      v_vin = 12'h250;
      v_aux = 12'h3FF;
      fe_delay = 4'h0;
      wr(8'hD4, 16'h0089);
      wr(8'hD3, 16'h0001);
      wait_done;
      wait_done;
      rd(8'hD3, 16'h0001);
      wr(8'hD3, 16'h0000);
      chk("busy", 16'h0000, {15'h0000, sampling_busy});
      rd(8'hD0, 16'h0100);
      rd(8'hD1, 16'h0250);
      rd(8'hD2, 16'h0300);
      end_sim();
   end
endmodule
`default_nettype wire
